//--- pkg/rcd_pkg.sv
// Shared constants and types for the small RISC core datapath.
// Assumes a single pclk domain that also serves as the oscillator.
`default_nettype none

package rcd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned RCD_INSN_NS      = 200;  // Cycle at ref rate
  localparam int unsigned RCD_REF_OSC_MHZ  = 20;   // Reference osc rate
  // Oscillator periods per instruction cycle
  localparam int unsigned RCD_OSC_PER_INSN =
    (RCD_INSN_NS * RCD_REF_OSC_MHZ) / 1000;
  localparam logic [1:0]  RCD_PH_LAST      =
    2'(RCD_OSC_PER_INSN - 1);
  localparam logic [1:0]  RCD_PH_HALF      =
    2'(RCD_OSC_PER_INSN / 2);

  // ----------------------------------------------------------------
  // Bus register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RCD_OFS_CTRL  = 8'h00;  // Run, osc, options
  localparam logic [7:0] RCD_OFS_PULL  = 8'h04;  // Weak pull-up enables
  localparam logic [7:0] RCD_OFS_WAKE  = 8'h08;  // Wake-on-change enables
  localparam logic [7:0] RCD_OFS_TRIS  = 8'h0C;  // Pin direction, 1 = in
  localparam logic [7:0] RCD_OFS_CORE  = 8'h10;  // PC, flags, accumulator
  localparam logic [7:0] RCD_OFS_PORT  = 8'h14;  // Pin levels and latch
  localparam logic [4:0] RCD_CTRL_RST  = 5'h05;  // Run, internal osc
  localparam logic [5:0] RCD_PULL_RST  = 6'h00;
  localparam logic [5:0] RCD_WAKE_RST  = 6'h00;
  localparam logic [5:0] RCD_TRIS_RST  = 6'h3F;
  localparam logic [5:0] RCD_OPT_PINS  = 6'h0B;  // Pins 0, 1 and 3

  // Control field positions
  localparam int unsigned RCD_CTRL_RUN    = 0;
  localparam int unsigned RCD_CTRL_OSC_LO = 1;
  localparam int unsigned RCD_CTRL_QOUT   = 3;
  localparam int unsigned RCD_CTRL_RPIN   = 4;

  // Oscillator modes
  localparam logic [1:0] RCD_OSC_LOWP  = 2'h0;  // Low power crystal
  localparam logic [1:0] RCD_OSC_XTAL  = 2'h1;  // Crystal
  localparam logic [1:0] RCD_OSC_INTRC = 2'h2;
  localparam logic [1:0] RCD_OSC_EXTRC = 2'h3;

  // ----------------------------------------------------------------
  // Data memory map
  // ----------------------------------------------------------------
  localparam int unsigned RCD_DMEM_DEPTH = 32;
  localparam logic [4:0] RCD_SPR_INDF   = 5'h00;  // Indirect window
  localparam logic [4:0] RCD_SPR_TIMER  = 5'h01;  // Plain cell here
  localparam logic [4:0] RCD_SPR_PCL    = 5'h02;
  localparam logic [4:0] RCD_SPR_STATUS = 5'h03;
  localparam logic [4:0] RCD_SPR_FSR    = 5'h04;
  localparam logic [4:0] RCD_SPR_GPIO   = 5'h06;
  localparam int unsigned RCD_ST_C  = 0;
  localparam int unsigned RCD_ST_NB = 1;
  localparam int unsigned RCD_ST_Z  = 2;
  localparam logic [7:0] RCD_STATUS_RST = 8'h18;
  localparam logic [7:0] RCD_PC_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Opcode layout and function codes
  // ----------------------------------------------------------------
  localparam int unsigned RCD_OP_DEST = 5;  // 1 = result to file
  localparam int unsigned RCD_OP_SRCW = 6;  // Single op on accumulator
  localparam logic [3:0] RCD_F_NOP   = 4'h0;
  localparam logic [3:0] RCD_F_ADD   = 4'h1;
  localparam logic [3:0] RCD_F_SUB   = 4'h2;
  localparam logic [3:0] RCD_F_AND   = 4'h3;
  localparam logic [3:0] RCD_F_IOR   = 4'h4;
  localparam logic [3:0] RCD_F_XOR   = 4'h5;
  localparam logic [3:0] RCD_F_MOV   = 4'h6;
  localparam logic [3:0] RCD_F_COM   = 4'h7;
  localparam logic [3:0] RCD_F_RL    = 4'h8;
  localparam logic [3:0] RCD_F_RR    = 4'h9;
  localparam logic [3:0] RCD_F_CLR   = 4'hA;
  localparam logic [3:0] RCD_F_MOVWF = 4'hB;
  localparam logic [3:0] RCD_F_ADDL  = 4'hC;
  localparam logic [3:0] RCD_F_ANDL  = 4'hD;
  localparam logic [3:0] RCD_F_MOVL  = 4'hE;
  localparam logic [3:0] RCD_F_GOTO  = 4'hF;
  localparam logic [11:0] RCD_OP_NOP = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic z;
    logic nb;
    logic c;
  } rcd_flags_t;

  typedef struct packed {
    logic [7:0] val;  // Result byte
    rcd_flags_t fl;   // New flag values
    rcd_flags_t upd;  // Which flags this op changes
  } rcd_alu_t;

endpackage

`default_nettype wire

//--- logic/rcd_core_datapath.sv
// Datapath of a small 8-bit Harvard core with pin options and APB
// control. Assumes program memory answers combinationally within
// one pclk and that pclk is the oscillator clock.
//
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none

// What this block does
// [RULE_01] Fetch whole 12-bit opcode on separate bus
// [RULE_02] Fetch next opcode while current executes
// [RULE_03] Non-branch instructions finish in one cycle
// [RULE_04] Branches take two cycles, prefetch discarded
// [RULE_05] Four oscillator periods per cycle; quarter output
// [RULE_06] Special registers and PC live in data memory
// [RULE_07] 8-bit ALU: add, subtract, shift, logic
// [RULE_08] Arithmetic is two's complement
// [RULE_09] Accumulator with file or literal operand
// [RULE_10] Accumulator has no data memory address
// [RULE_11] ALU updates carry, nibble and zero flags
// [RULE_12] Subtraction carries act as borrow indications
// [RULE_13] Zero on all-zero result; no borrow sets carry
// [RULE_14] Reset pin low resets core when enabled
// [RULE_15] Reset pin keeps its pull-up on
// [RULE_16] Pins 0, 1, 3 pull-up and wake options
// [RULE_17] Crystal output only in crystal modes
// [RULE_18] Pin two feeds timer external clock
module rcd_core_datapath
  import rcd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       pmem_addr,
  output logic             pmem_rd,
  input  wire logic [11:0] pmem_data,
  input  wire logic [5:0]  gp_in,
  output logic [5:0]       gp_out,
  output logic [5:0]       gp_oe,
  output logic [5:0]       gp_pullup,
  output logic             crystal_drive,
  output logic             wake_pulse,
  output logic             timer_clk_rise,
  output logic             insn_strobe
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Resolve the indirect window through the pointer register
  function automatic logic [4:0] rcd_eff(input logic [4:0] a,
                                         input logic [7:0] ptr);
    rcd_eff = (a == RCD_SPR_INDF) ? ptr[4:0] : a;
  endfunction

  // One ALU operation; f is file, literal or accumulator operand
  function automatic rcd_alu_t rcd_alu(input logic [3:0] fn,
                                       input logic [7:0] w,
                                       input logic [7:0] f,
                                       input logic       cin);
    logic [8:0] sum;
    logic [4:0] nib;
    rcd_alu_t   r;
    sum = 9'h000;
    nib = 5'h00;
    r   = '0;
    case (fn)
      RCD_F_ADD, RCD_F_ADDL: begin
        // Plain binary add is two's complement; see [RULE_08]
        sum       = {1'b0, w} + {1'b0, f};
        nib       = {1'b0, w[3:0]} + {1'b0, f[3:0]};
        r.val     = sum[7:0];
        r.fl.c    = sum[8];
        r.fl.nb   = nib[4];
        r.upd     = 3'b111;
      end
      RCD_F_SUB: begin
        // f - w as f + ~w + 1: carry high means no borrow;
        // see [RULE_12] [RULE_13]
        sum       = {1'b0, f} + {1'b0, ~w} + 9'h001;
        nib       = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        r.val     = sum[7:0];
        r.fl.c    = sum[8];
        r.fl.nb   = nib[4];
        r.upd     = 3'b111;
      end
      RCD_F_AND, RCD_F_ANDL: begin
        r.val     = w & f;
        r.upd.z   = 1'b1;
      end
      RCD_F_IOR: begin
        r.val     = w | f;
        r.upd.z   = 1'b1;
      end
      RCD_F_XOR: begin
        r.val     = w ^ f;
        r.upd.z   = 1'b1;
      end
      RCD_F_MOV: begin
        r.val     = f;
        r.upd.z   = 1'b1;
      end
      RCD_F_COM: begin
        r.val     = ~f;
        r.upd.z   = 1'b1;
      end
      RCD_F_RL: begin
        // Rotate through carry, only carry changes
        r.val     = {f[6:0], cin};
        r.fl.c    = f[7];
        r.upd.c   = 1'b1;
      end
      RCD_F_RR: begin
        r.val     = {cin, f[7:1]};
        r.fl.c    = f[0];
        r.upd.c   = 1'b1;
      end
      RCD_F_CLR: begin
        r.val     = 8'h00;
        r.upd.z   = 1'b1;
      end
      RCD_F_MOVWF: begin
        r.val     = w;
      end
      RCD_F_MOVL: begin
        r.val     = f;
      end
      default: begin
        r.val     = 8'h00;
      end
    endcase
    // Zero flag follows the 8-bit result; see [RULE_13]
    r.fl.z = (r.val == 8'h00);
    rcd_alu = r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  logic [5:0] pin_s1_reg;   // First stage, read by second only
  logic [5:0] pin_s2_reg;   // Safe pin levels
  logic [5:0] pin_prev_reg; // Previous safe levels

  // Two flops before any logic looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg   <= 6'h00;
      pin_s2_reg   <= 6'h00;
      pin_prev_reg <= 6'h00;
    end else begin
      pin_s1_reg   <= gp_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  logic [4:0] ctrl_reg;      // Run, osc mode, clock out, reset pin
  logic [5:0] pull_reg;      // Pull-up requests
  logic [5:0] wake_reg;      // Wake-on-change enables
  logic [5:0] tris_reg;      // Direction, 1 = input
  logic [31:0] prdata_reg;   // Read data for the access phase
  logic [31:0] rd_mux;       // Selected read word

  wire        bus_wr   = psel & penable & pwrite & pstrb[0];
  wire        bus_set  = psel & ~penable;
  wire        hit_ctrl = (paddr == RCD_OFS_CTRL);
  wire        hit_pull = (paddr == RCD_OFS_PULL);
  wire        hit_wake = (paddr == RCD_OFS_WAKE);
  wire        hit_tris = (paddr == RCD_OFS_TRIS);
  wire        hit_core = (paddr == RCD_OFS_CORE);
  wire        hit_port = (paddr == RCD_OFS_PORT);
  wire        hit_any  = hit_ctrl | hit_pull | hit_wake | hit_tris |
                         hit_core | hit_port;
  wire [1:0]  osc_mode = ctrl_reg[RCD_CTRL_OSC_LO +: 2];
  wire        run      = ctrl_reg[RCD_CTRL_RUN];
  wire        rpin_en  = ctrl_reg[RCD_CTRL_RPIN];

  // Zero-wait slave; unmapped access errors on the access phase
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_reg;

  // Software writes, byte lane 0 carries every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= RCD_CTRL_RST;
      pull_reg <= RCD_PULL_RST;
      wake_reg <= RCD_WAKE_RST;
      tris_reg <= RCD_TRIS_RST;
    end else if (bus_wr) begin
      if (hit_ctrl) ctrl_reg <= pwdata[4:0];
      if (hit_pull) pull_reg <= pwdata[5:0] & RCD_OPT_PINS; // see [RULE_16]
      if (hit_wake) wake_reg <= pwdata[5:0] & RCD_OPT_PINS; // see [RULE_16]
      if (hit_tris) tris_reg <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  logic [1:0]  phase_reg;  // Oscillator period within a cycle
  logic [7:0]  pc_reg;     // Program counter, seen at PCL
  logic [11:0] ir_reg;     // Prefetched opcode being executed
  logic [7:0]  w_reg;      // Accumulator, not memory mapped
  logic        qrate_reg;  // Quarter rate clock output
  logic        wake_reg_q; // Registered wake pulse
  logic        tclk_reg;   // Registered timer edge pulse
  logic [7:0]  dmem [RCD_DMEM_DEPTH];  // Data memory cells

  // Reset pin, when enabled, resets the core synchronously; the
  // bus registers survive so software can still see the setting
  wire core_rst = rpin_en & ~pin_s2_reg[3];  // see [RULE_14]

  // Four periods per cycle; execute on the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else if (core_rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;  // see [RULE_05]
    end
  end

  wire exec = run & ~core_rst & (phase_reg == RCD_PH_LAST);
  assign insn_strobe = exec;

  // ----------------------------------------------------------------
  // Decode and operand selection
  // ----------------------------------------------------------------
  wire [3:0]  fn      = ir_reg[11:8];
  wire [7:0]  lit     = ir_reg[7:0];
  wire        is_lit  = (fn == RCD_F_ADDL) | (fn == RCD_F_ANDL) |
                        (fn == RCD_F_MOVL);
  wire        is_one  = (fn == RCD_F_MOV) | (fn == RCD_F_COM) |
                        (fn == RCD_F_RL)  | (fn == RCD_F_RR);
  wire [4:0]  ea      = rcd_eff(ir_reg[4:0], dmem[RCD_SPR_FSR]);
  wire [7:0]  status  = dmem[RCD_SPR_STATUS];
  // File read; PCL and port map onto live state; see [RULE_06]
  wire [7:0]  f_rd    = (ea == RCD_SPR_PCL)  ? pc_reg :
                        (ea == RCD_SPR_GPIO) ? {2'b00, pin_s2_reg} :
                        (ea == RCD_SPR_INDF) ? 8'h00 : dmem[ea];
  // Literal, accumulator or file operand; see [RULE_09]
  wire [7:0]  opnd    = is_lit ? lit :
                        (is_one & ir_reg[RCD_OP_SRCW]) ? w_reg : f_rd;
  wire rcd_alu_t alu  = rcd_alu(fn, w_reg, opnd, status[RCD_ST_C]);
  wire        dest_f  = (fn == RCD_F_MOVWF) |
                        (~is_lit & (fn != RCD_F_GOTO) &
                         (fn != RCD_F_NOP) & ir_reg[RCD_OP_DEST]);
  wire        to_w    = ~dest_f & (fn != RCD_F_GOTO) &
                        (fn != RCD_F_NOP);
  wire        wr_f    = exec & dest_f;
  wire        pcl_wr  = wr_f & (ea == RCD_SPR_PCL);
  wire        jump    = exec & (fn == RCD_F_GOTO);
  wire        branch  = jump | pcl_wr;

  // ----------------------------------------------------------------
  // Fetch, program counter and accumulator
  // ----------------------------------------------------------------
  assign pmem_addr = pc_reg;  // Own 12-bit bus; see [RULE_01]
  assign pmem_rd   = exec;

  // Fetch overlaps execute; a branch drops the prefetched opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= RCD_PC_RST;
      ir_reg <= RCD_OP_NOP;
      w_reg  <= 8'h00;
    end else if (core_rst) begin
      pc_reg <= RCD_PC_RST;
      ir_reg <= RCD_OP_NOP;
      w_reg  <= 8'h00;
    end else if (exec) begin
      // Next opcode lands while this one executes; see [RULE_02]
      ir_reg <= branch ? RCD_OP_NOP : pmem_data;  // see [RULE_04]
      if (jump) begin
        pc_reg <= lit;
      end else if (pcl_wr) begin
        pc_reg <= alu.val;
      end else begin
        pc_reg <= pc_reg + 8'h01;  // see [RULE_03]
      end
      if (to_w) w_reg <= alu.val;  // see [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // Data memory cells
  // ----------------------------------------------------------------
  // One writer per cell; status also takes the ALU flags
  for (genvar i = 0; i < RCD_DMEM_DEPTH; i++) begin : g_cell
    localparam logic [4:0] IDX = 5'(i);
    wire        hit = wr_f & (ea == IDX);
    wire [7:0]  dat = hit ? alu.val : dmem[i];
    if (i == int'(RCD_SPR_STATUS)) begin : g_st
      // Flags land over any direct write; see [RULE_11]
      wire [7:0] nxt = {dat[7:3],
        (exec & alu.upd.z)  ? alu.fl.z  : dat[RCD_ST_Z],
        (exec & alu.upd.nb) ? alu.fl.nb : dat[RCD_ST_NB],
        (exec & alu.upd.c)  ? alu.fl.c  : dat[RCD_ST_C]};
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dmem[i] <= RCD_STATUS_RST;
        end else if (core_rst) begin
          dmem[i] <= RCD_STATUS_RST;
        end else begin
          dmem[i] <= nxt;  // see [RULE_07]
        end
      end
    end else begin : g_gen
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dmem[i] <= 8'h00;
        end else if (core_rst) begin
          dmem[i] <= 8'h00;
        end else begin
          dmem[i] <= dat;  // see [RULE_06]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin options
  // ----------------------------------------------------------------
  wire xtal  = (osc_mode == RCD_OSC_LOWP) | (osc_mode == RCD_OSC_XTAL);
  wire qout  = ~xtal & ctrl_reg[RCD_CTRL_QOUT];
  wire [5:0] latch = dmem[RCD_SPR_GPIO][5:0];
  wire [5:0] chg   = (pin_s2_reg ^ pin_prev_reg) & wake_reg;

  // Crystal driver only in the two crystal modes; see [RULE_17]
  assign crystal_drive = xtal;
  // Pin 3 is input only; pin 4 is lost to crystal or clock out
  assign gp_oe = {~tris_reg[5], ~xtal & (qout | ~tris_reg[4]),
                  1'b0, ~tris_reg[2:0]};
  assign gp_out = {latch[5], qout ? qrate_reg : latch[4], latch[3:0]};
  // Reset pin keeps its pull-up whatever software says
  assign gp_pullup = pull_reg | {2'b00, rpin_en, 3'b000};  // see [RULE_15]
  assign wake_pulse     = wake_reg_q;
  assign timer_clk_rise = tclk_reg;

  // Quarter rate output, pin change wake and timer edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qrate_reg  <= 1'b0;
      wake_reg_q <= 1'b0;
      tclk_reg   <= 1'b0;
    end else begin
      qrate_reg  <= (phase_reg + 2'h1) >= RCD_PH_HALF;  // see [RULE_05]
      wake_reg_q <= |chg;                               // see [RULE_16]
      tclk_reg   <= pin_s2_reg[2] & ~pin_prev_reg[2];   // see [RULE_18]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign rd_mux =
    hit_ctrl ? {27'h0, ctrl_reg} :
    hit_pull ? {26'h0, pull_reg} :
    hit_wake ? {26'h0, wake_reg} :
    hit_tris ? {26'h0, tris_reg} :
    hit_core ? {8'h00, pc_reg, status, w_reg} :
    hit_port ? {18'h0, pin_s2_reg, 2'b00, latch} : 32'h0;

  // Read data captured in setup so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (bus_set & ~pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

endmodule

`default_nettype wire

//--- dv/rcd_core_datapath_checker.sv
// Concurrent checks on the core datapath top-level ports.
// Assumes one pclk domain with asynchronous active-low presetn.
`default_nettype none

module rcd_core_datapath_checker
  import rcd_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr,
  input wire logic [7:0] pmem_addr,
  input wire logic       pmem_rd,
  input wire logic       insn_strobe,
  input wire logic [5:0] gp_oe,
  input wire logic [5:0] gp_pullup,
  input wire logic       crystal_drive,
  input wire logic       timer_clk_rise
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Clocking and decode helper
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic map_hit;  // Access lands on a decoded register
  assign map_hit = paddr inside {RCD_OFS_CTRL, RCD_OFS_PULL,
    RCD_OFS_WAKE, RCD_OFS_TRIS, RCD_OFS_CORE, RCD_OFS_PORT};

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_fetch_rate; insn_strobe |=> !insn_strobe [*3]; endproperty
  a_fetch_rate: assert property (p_fetch_rate)
    else $error("opcode fetches closer than four clocks");
  property p_fetch_bus;
    pmem_rd |-> insn_strobe && pmem_addr == $past(pmem_addr, 3);
  endproperty
  a_fetch_bus: assert property (p_fetch_bus)
    else $error("program read not aligned to execute cycle");
  // Core pin reset may also pull the fetch address back to zero
  property p_pc_hold;
    $changed(pmem_addr) |-> $past(insn_strobe) || pmem_addr == 8'h00;
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("fetch address moved outside an execute edge");
  property p_xtal_pin; crystal_drive |-> !gp_oe[4]; endproperty
  a_xtal_pin: assert property (p_xtal_pin)
    else $error("crystal output pin driven as port in crystal mode");
  property p_pull_pins; (gp_pullup & 6'h34) == 6'h00; endproperty
  a_pull_pins: assert property (p_pull_pins)
    else $error("pull-up enabled on a pin without that option");
  property p_tmr_pulse; timer_clk_rise |=> !timer_clk_rise; endproperty
  a_tmr_pulse: assert property (p_tmr_pulse)
    else $error("timer clock edge pulse longer than one clock");
  property p_input_only; gp_oe[3] == 1'b0; endproperty
  a_input_only: assert property (p_input_only)
    else $error("input-only pin has its driver enabled");
  property p_slverr; pslverr == (psel && penable && !map_hit); endproperty
  a_slverr: assert property (p_slverr)
    else $error("bus error flag does not match the address decode");
endmodule

bind rcd_core_datapath rcd_core_datapath_checker u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pslverr(pslverr), .pmem_addr(pmem_addr),
  .pmem_rd(pmem_rd), .insn_strobe(insn_strobe), .gp_oe(gp_oe),
  .gp_pullup(gp_pullup), .crystal_drive(crystal_drive),
  .timer_clk_rise(timer_clk_rise)
);

`default_nettype wire

//--- dv/rcd_pmem_model.sv
// Program memory model on the core's opcode fetch bus.
// Assumes the bench loads opcodes into mem before reset ends.
`default_nettype none

module rcd_pmem_model
  import rcd_pkg::*;
(
  input  wire logic [7:0] pmem_addr,
  output logic [11:0]     pmem_data,
  input  wire logic       pmem_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] mem [256];  // One whole opcode per word

  // Empty words execute as no-operation
  initial foreach (mem[i]) mem[i] = RCD_OP_NOP;

  // Whole word in one cycle; inverted outside a read so stale
  // data can never pass for a valid fetch
  assign pmem_data = pmem_rd ? mem[pmem_addr] :
                     ~mem[pmem_addr];
endmodule

`default_nettype wire

//--- dv/test_rcd_core_datapath.sv
// Self-checking bench for the core datapath, driven over APB.
// Assumes the program memory model and the checker bind are built.
`default_nettype none
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin \
  err_total++; $display("Error %s exp %0h got %0h", n, x, g); end end

module test_rcd_core_datapath import rcd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pmem_rd, crystal_drive, wake_pulse, timer_clk_rise;
  logic        insn_strobe, e;
  logic [7:0]  paddr, pmem_addr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [11:0] pmem_data;
  logic [5:0]  gp_in, gp_out, gp_oe, gp_pullup;
  logic [7:0]  seq [$];
  int          err_total, tests_run, cyc, wk, tk, hi;
  // Load, add, store, load, subtract, branch, skipped, branch loop
  localparam logic [11:0] PROG [8] = '{12'hE0F, 12'hC01, 12'hB28,
    12'hE01, 12'h208, 12'hF07, 12'hEAA, 12'hF07};
  localparam int FETCH [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 7};
  localparam logic [31:0] RST [4] = '{32'h05, 32'h00, 32'h00, 32'h3F};

  rcd_core_datapath dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data), .gp_in(gp_in), .gp_out(gp_out),
    .gp_oe(gp_oe), .gp_pullup(gp_pullup),
    .crystal_drive(crystal_drive), .wake_pulse(wake_pulse),
    .timer_clk_rise(timer_clk_rise), .insn_strobe(insn_strobe));
  rcd_pmem_model u_pmem (.pmem_addr(pmem_addr),
    .pmem_data(pmem_data), .pmem_rd(pmem_rd));

  // ----------------------------------------------------------------
  // Clock, monitors and hang guard
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Sampled on the falling edge, well clear of the design's updates
  always @(negedge pclk) begin
    if (insn_strobe === 1'b1 && seq.size() < 10)
      seq.push_back(pmem_addr);
    wk += int'(wake_pulse === 1'b1);
    tk += int'(timer_clk_rise === 1'b1);
    hi += int'(gp_out[4] === 1'b1);
  end
  // The whole sequence needs well under a thousand clocks
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Bus and closing tasks
  // ----------------------------------------------------------------
  // Setup, then access held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    pstrb  = 4'hF;
    gp_in  = 6'h08;  // Reset pin idles high
    repeat (16) @(posedge pclk);
    foreach (PROG[i]) u_pmem.mem[i] = PROG[i];
    presetn <= 1'b1;
    foreach (RST[i]) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset value", RST[i], q)
    end
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, e)
    repeat (60) @(posedge pclk);
    `CHK("fetch count", 10, seq.size())
    foreach (FETCH[i]) `CHK("fetch addr", FETCH[i], seq[i])
    // Borrow-free subtract 0x10 - 0x01; prefetched load discarded
    xfer(1'b0, 8'h10, 32'h0);
    `CHK("status and acc", 16'h190F, q[15:0])
    xfer(1'b1, 8'h04, 32'h3F);
    xfer(1'b0, 8'h04, 32'h0);
    `CHK("pull mask", 32'h0B, q)
    `CHK("pull pins", 6'h0B, gp_pullup)
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'h15);
    @(negedge pclk);
    `CHK("reset pin pull", 6'h08, gp_pullup)
    @(posedge pclk);
    gp_in[3] <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK("fetch held in reset", 8'h00, pmem_addr)
    gp_in[3] <= 1'b1;
    xfer(1'b1, 8'h00, 32'h05);
    xfer(1'b1, 8'h08, 32'h0B);
    wk = 0;
    tk = 0;
    repeat (2) begin
      gp_in[2] <= 1'b1;
      repeat (8) @(posedge pclk);
      gp_in[2] <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    `CHK("timer rises", 2, tk)
    `CHK("wake on pin two", 0, wk)
    gp_in[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("wake on pin zero", 1, wk)
    xfer(1'b1, 8'h0C, 32'h0);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 8'h00, 32'(m * 2 + 1));
      @(negedge pclk);
      `CHK("crystal drive", m < 2, crystal_drive)
      `CHK("osc pin enable", m >= 2, gp_oe[4])
    end
    xfer(1'b1, 8'h00, 32'h0D);
    hi = 0;
    repeat (8) @(posedge pclk);
    `CHK("quarter clock highs", 4, hi)
    wrap_up();
  end
endmodule

`default_nettype wire
